// file: logic/tgc_pkg.sv
// Package for the counter gate control block: map, fields, types
package tgc_pkg;
    localparam logic [11:0] ADDR_GATE_CTRL = 12'h000;
    localparam logic [11:0] ADDR_COUNT_LOW = 12'h004;
    localparam logic [11:0] ADDR_COUNT_HIGH = 12'h008;
    localparam logic [11:0] ADDR_INT_FLAG = 12'h00C;
    localparam logic [11:0] ADDR_INT_MASK = 12'h010;
    localparam logic [11:0] ADDR_RUN_CTRL = 12'h014;

    localparam int GE_BIT = 7;
    localparam int POL_BIT = 6;
    localparam int TM_BIT = 5;
    localparam int SPM_BIT = 4;
    localparam int ARM_BIT = 3;
    localparam int VAL_BIT = 2;
    localparam int SS_LSB = 0;
    localparam int SS_W = 2;
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int SYNC_W = 3;

    localparam logic [7:0] GATE_CTRL_RESET = 8'h00;
    localparam logic [7:0] TIMER_MAX = 8'hFF;

    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_OVF = 2'h1;
    localparam logic [1:0] SRC_AUX0 = 2'h2;
    localparam logic [1:0] SRC_AUX1 = 2'h3;

    typedef struct packed {
        logic gate_enable_bit;
        logic gate_polarity_bit;
        logic gate_toggle_enable;
        logic gate_single_pulse_enable;
        logic [1:0] gate_source_select;
    } tgc_ctrl_s;

    typedef enum logic [2:0] {
        SP_IDLE = 3'b001,
        SP_WAIT = 3'b010,
        SP_OPEN = 3'b100
    } tgc_sp_e;
endpackage

// file: logic/tgc_sync.sv
// Three-stage pin synchroniser with agreement of last two stages
`timescale 1ns/10ps
module tgc_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic async_in,
    output logic sync_out
);
    logic [2:0] stage_reg;
    logic out_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage_reg <= 3'h0;
            out_reg <= 1'b0;
        end else begin
            stage_reg <= {stage_reg[1:0], async_in};
            if (stage_reg[2] == stage_reg[1]) begin
                out_reg <= stage_reg[2];
            end
        end
    end

    assign sync_out = out_reg;
endmodule

// file: logic/tgc_ovf_timer.sv
// Free 8-bit companion timer giving a one-cycle rollover pulse
`timescale 1ns/10ps
module tgc_ovf_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    output logic [7:0] count,
    output logic ovf_pulse
);
    logic [7:0] count_reg;
    logic pulse_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= 8'h00;
            pulse_reg <= 1'b0;
        end else begin
            if (tick) begin
                count_reg <= count_reg + 8'h01;
            end
            pulse_reg <= tick && (count_reg == tgc_pkg::TIMER_MAX);
        end
    end

    assign count = count_reg;
    assign ovf_pulse = pulse_reg;
endmodule

// file: logic/tgc_gate.sv
// Gate control for a 16-bit gated counter with APB registers
`timescale 1ns/10ps
module tgc_gate (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic gate_input_pin,
    input wire logic aux_gate_a,
    input wire logic aux_gate_b,
    output logic irq
);
    // Bus decode
    wire bus_acc = psel && penable;
    wire wr_en = bus_acc && pwrite;
    wire hit_ctrl = paddr == tgc_pkg::ADDR_GATE_CTRL;
    wire hit_low = paddr == tgc_pkg::ADDR_COUNT_LOW;
    wire hit_high = paddr == tgc_pkg::ADDR_COUNT_HIGH;
    wire hit_flag = paddr == tgc_pkg::ADDR_INT_FLAG;
    wire hit_mask = paddr == tgc_pkg::ADDR_INT_MASK;
    wire hit_run = paddr == tgc_pkg::ADDR_RUN_CTRL;
    wire hit_any = hit_ctrl || hit_low || hit_high || hit_flag
        || hit_mask || hit_run;

    tgc_pkg::tgc_ctrl_s ctrl_reg;
    logic arm_reg;
    logic tog_reg;
    logic val_reg;
    logic src_d_reg;
    logic flag_reg;
    logic mask_reg;
    logic run_reg;
    logic [15:0] cnt_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    tgc_pkg::tgc_sp_e sp_reg;
    tgc_pkg::tgc_sp_e sp_next;

    // Pin sources cross in through three stage flops and an agreement output flop
    logic pin_s;
    logic aux_a_s;
    logic aux_b_s;
    logic ovf_pulse;
    logic [7:0] ovf_count;

    tgc_sync u_sync_pin (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(gate_input_pin),
        .sync_out(pin_s)
    );
    tgc_sync u_sync_a (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(aux_gate_a),
        .sync_out(aux_a_s)
    );
    tgc_sync u_sync_b (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(aux_gate_b),
        .sync_out(aux_b_s)
    );
    tgc_ovf_timer u_ovf (
        .pclk(pclk),
        .presetn(presetn),
        .tick(1'b1),
        .count(ovf_count),
        .ovf_pulse(ovf_pulse)
    );

    // Source select, polarity, edge detect
    wire sel_src = (ctrl_reg.gate_source_select == tgc_pkg::SRC_PIN) ?
        pin_s :
        (ctrl_reg.gate_source_select == tgc_pkg::SRC_OVF) ? ovf_pulse :
        (ctrl_reg.gate_source_select == tgc_pkg::SRC_AUX0) ? aux_a_s :
        aux_b_s;
    wire pol_src = ctrl_reg.gate_polarity_bit ? sel_src : ~sel_src;
    wire src_rise = pol_src && !src_d_reg;
    logic tog_d_reg;
    // Toggle stage output
    wire tog_out = ctrl_reg.gate_toggle_enable ? tog_reg : pol_src;
    wire tog_rise = tog_out && !(ctrl_reg.gate_toggle_enable ?
        tog_d_reg : src_d_reg);
    // Open already in the catching cycle, else the first cycle is lost
    wire sp_catch = (sp_reg == tgc_pkg::SP_WAIT) && tog_rise && arm_reg;
    wire sp_out = ctrl_reg.gate_single_pulse_enable ?
        ((sp_reg == tgc_pkg::SP_OPEN) || sp_catch) && tog_out : tog_out;
    wire gate_val = sp_out;
    wire val_fall = val_reg && !gate_val;
    wire count_ok = run_reg && (!ctrl_reg.gate_enable_bit || gate_val);

    // Single-pulse sequencing
    always_comb begin
        sp_next = sp_reg;
        unique case (sp_reg)
            tgc_pkg::SP_IDLE: begin
                if (arm_reg && ctrl_reg.gate_single_pulse_enable) begin
                    sp_next = tgc_pkg::SP_WAIT;
                end
            end
            tgc_pkg::SP_WAIT: begin
                if (!arm_reg) begin
                    sp_next = tgc_pkg::SP_IDLE;
                end else if (tog_rise) begin
                    sp_next = tgc_pkg::SP_OPEN;
                end
            end
            tgc_pkg::SP_OPEN: begin
                if (!tog_out || !arm_reg) begin
                    sp_next = tgc_pkg::SP_IDLE;
                end
            end
        endcase
    end

    wire sp_done = (sp_reg == tgc_pkg::SP_OPEN) && !tog_out;
    wire wr_ctrl = wr_en && hit_ctrl;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= '0;
            arm_reg <= 1'b0;
            run_reg <= 1'b0;
            mask_reg <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.gate_enable_bit <= pwdata[tgc_pkg::GE_BIT];
                ctrl_reg.gate_polarity_bit <= pwdata[tgc_pkg::POL_BIT];
                ctrl_reg.gate_toggle_enable <= pwdata[tgc_pkg::TM_BIT];
                ctrl_reg.gate_single_pulse_enable <= pwdata[tgc_pkg::SPM_BIT];
                ctrl_reg.gate_source_select <=
                    pwdata[tgc_pkg::SS_LSB +: tgc_pkg::SS_W];
            end
            // Hardware clear loses to a software set in the same cycle
            if (wr_ctrl) begin
                arm_reg <= pwdata[tgc_pkg::ARM_BIT];
            end else if (sp_done) begin
                arm_reg <= 1'b0;
            end
            if (wr_en && hit_run) begin
                run_reg <= pwdata[0];
            end
            if (wr_en && hit_mask) begin
                mask_reg <= pwdata[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_reg <= tgc_pkg::SP_IDLE;
            tog_reg <= 1'b0;
            tog_d_reg <= 1'b0;
            src_d_reg <= 1'b0;
            val_reg <= 1'b0;
        end else begin
            sp_reg <= sp_next;
            src_d_reg <= pol_src;
            tog_d_reg <= tog_out;
            val_reg <= gate_val;
            if (!ctrl_reg.gate_toggle_enable) begin
                tog_reg <= 1'b0;
            end else if (src_rise) begin
                tog_reg <= !tog_reg;
            end
        end
    end

    // Flag: set wins over a write-one clear
    wire flag_clr = wr_en && hit_flag && pwdata[0];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            if (val_fall) begin
                flag_reg <= 1'b1;
            end else if (flag_clr) begin
                flag_reg <= 1'b0;
            end
            irq_reg <= (flag_reg || val_fall) && mask_reg;
        end
    end

    // Counter with byte writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 16'h0000;
        end else if (wr_en && hit_low) begin
            cnt_reg[7:0] <= pwdata[7:0];
        end else if (wr_en && hit_high) begin
            cnt_reg[15:8] <= pwdata[7:0];
        end else if (count_ok) begin
            cnt_reg <= cnt_reg + 16'h0001;
        end
    end

    wire [7:0] ctrl_rd = {ctrl_reg.gate_enable_bit,
        ctrl_reg.gate_polarity_bit, ctrl_reg.gate_toggle_enable,
        ctrl_reg.gate_single_pulse_enable, arm_reg, val_reg,
        ctrl_reg.gate_source_select};
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
        hit_low ? {24'h000000, cnt_reg[7:0]} :
        hit_high ? {24'h000000, cnt_reg[15:8]} :
        hit_flag ? {31'h00000000, flag_reg} :
        hit_mask ? {31'h00000000, mask_reg} :
        hit_run ? {31'h00000000, run_reg} : 32'h00000000;

    // Zero-wait answer; pready registered high during access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && !hit_any;
            if (psel && !penable && !pwrite) begin
                prdata_reg <= rd_mux;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;

    // Checks
    sequence arm_write_s;
        wr_ctrl && pwdata[tgc_pkg::ARM_BIT];
    endsequence
    tog_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.gate_toggle_enable |=> !tog_reg)
        else $error("toggle not held clear");
    tog_flip_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_toggle_enable && src_rise |=> tog_reg != $past(tog_reg))
        else $error("toggle did not flip");
    arm_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp_done && !wr_ctrl |=> !arm_reg)
        else $error("arm not cleared");
    sp_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_enable_bit && ctrl_reg.gate_single_pulse_enable
        && !arm_reg && sp_reg != tgc_pkg::SP_OPEN |-> !count_ok)
        else $error("count without arm");
    flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        val_fall |=> flag_reg)
        else $error("flag not set on fall");
    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_reg && mask_reg |=> irq_reg)
        else $error("irq missing");
    irq_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !mask_reg |=> !irq_reg)
        else $error("irq while masked");
    gate_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_enable_bit && !gate_val && !wr_en
        |=> cnt_reg == $past(cnt_reg))
        else $error("counted with gate shut");
    sp_open_a: assert property (@(posedge pclk) disable iff (!presetn)
        arm_write_s ##1 (sp_reg == tgc_pkg::SP_WAIT && tog_rise && arm_reg)
        |=> sp_reg == tgc_pkg::SP_OPEN)
        else $error("single pulse did not open");
    count_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        count_ok && !wr_en |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step");

    // Single-pulse window
    sequence sp_open_s;
        sp_reg == tgc_pkg::SP_OPEN;
    endsequence
    sequence gate_low_s;
        !tog_out;
    endsequence
    sequence sp_catch_s;
        sp_reg == tgc_pkg::SP_WAIT && tog_rise && arm_reg;
    endsequence
    sp_close_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp_open_s ##0 gate_low_s |=> sp_reg == tgc_pkg::SP_IDLE)
        else $error("single pulse did not close");
    sp_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        sp_catch_s ##0 (ctrl_reg.gate_single_pulse_enable && run_reg)
        |-> count_ok)
        else $error("first gated cycle lost");
    sp_shut_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_toggle_enable && ctrl_reg.gate_single_pulse_enable
        && sp_reg == tgc_pkg::SP_IDLE |-> !gate_val)
        else $error("gate open outside window");

    // Event flag and gate level bit
    flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_reg && !flag_clr |=> flag_reg)
        else $error("flag lost");
    flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        flag_clr && !val_fall |=> !flag_reg)
        else $error("flag not cleared");
    val_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg.gate_enable_bit |=> val_reg == $past(gate_val))
        else $error("gate level bit stale");

    // Source routing
    pin_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_source_select == tgc_pkg::SRC_PIN |-> sel_src == pin_s)
        else $error("pin not routed");
    ovf_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_source_select == tgc_pkg::SRC_OVF
        |-> sel_src == ovf_pulse)
        else $error("overflow not routed");
    aux_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg.gate_source_select == tgc_pkg::SRC_AUX1
        |-> sel_src == aux_b_s)
        else $error("aux source not routed");

    // Count bytes
    cnt_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_high |=> cnt_reg[15:8] == $past(pwdata[7:0]))
        else $error("high byte not written");
    cnt_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_low |=> cnt_reg[7:0] == $past(pwdata[7:0]))
        else $error("low byte not written");
endmodule

// file: sim/tgc_gate_src.sv
// Far-side model: gate pin and two auxiliary gate sources
`timescale 1ns/10ps
module tgc_gate_src (
    input wire logic pclk,
    input wire logic [2:0] level,
    output logic gate_input_pin,
    output logic aux_gate_a,
    output logic aux_gate_b
);
    // Levels move just after an edge, like a real driver off this clock
    always_ff @(posedge pclk) begin
        {aux_gate_b, aux_gate_a, gate_input_pin} <= level;
    end
endmodule

// file: sim/test_timer_gate_control.sv
// Self-checking bench for the gate control block
`timescale 1ns/10ps
module test_timer_gate_control;
    typedef struct packed {
        logic [31:0] value;
        logic [31:0] mask;
        logic err;
    } tgc_note_s;
    localparam logic [11:0] CTL = tgc_pkg::ADDR_GATE_CTRL;
    localparam logic [11:0] FLG = tgc_pkg::ADDR_INT_FLAG;
    localparam logic [31:0] GE = 32'h1 << tgc_pkg::GE_BIT;
    localparam logic [31:0] POL = 32'h1 << tgc_pkg::POL_BIT;
    localparam logic [31:0] TM = 32'h1 << tgc_pkg::TM_BIT;
    localparam logic [31:0] SPM = 32'h1 << tgc_pkg::SPM_BIT;
    localparam logic [31:0] ARM = 32'h1 << tgc_pkg::ARM_BIT;
    localparam logic [31:0] VAL = 32'h1 << tgc_pkg::VAL_BIT;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, pin, aux_a, aux_b;
    logic [2:0] level = 3'h0;
    tgc_note_s notes[$];
    tgc_note_s nt;
    int n_errors = 0;
    int compares = 0;
    int k;
    logic [15:0] cnt = 16'h0000;

    initial forever #20 pclk = ~pclk;

    tgc_gate u_tgc_gate (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .gate_input_pin(pin), .aux_gate_a(aux_a), .aux_gate_b(aux_b),
        .irq(irq));
    tgc_gate_src u_tgc_gate_src (.pclk(pclk), .level(level),
        .gate_input_pin(pin), .aux_gate_a(aux_a), .aux_gate_b(aux_b));

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic conclude();
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            conclude();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e,
                      input logic [31:0] m, input logic er);
        notes.push_back('{e & m, m, er});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic pulse(input int hi, input int lo);
        level[0] <= 1'b1;
        idle(hi);
        level[0] <= 1'b0;
        idle(lo);
    endtask

    task automatic counts();
        rd(tgc_pkg::ADDR_COUNT_LOW, {24'h0, cnt[7:0]}, 32'hFFFFFFFF, 1'b0);
        rd(tgc_pkg::ADDR_COUNT_HIGH, {24'h0, cnt[15:8]}, 32'hFFFFFFFF, 1'b0);
    endtask

    // Result watcher: every read answer is matched to the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && pwrite === 1'b0) begin
            if (notes.size() == 0) begin
                chk("read note", 32'h1, 32'h0);
            end else begin
                nt = notes.pop_front();
                chk("prdata", nt.value, prdata & nt.mask);
                chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
            end
        end
    end

    initial begin
        repeat (100000) @(posedge pclk);
        n_errors++;
        conclude();
    end

    initial begin
        k = $urandom(32'h02FECEEB);
        idle(20);
        presetn <= 1'b1;
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        rd(12'h020, 32'h0, 32'hFFFFFFFF, 1'b1);
        // Active-low default with pin low shows the gate level set
        rd(CTL, {24'h0, tgc_pkg::GATE_CTRL_RESET} | VAL, 32'hFF, 1'b0);
        for (int s = 0; s < 3; s++) begin
            k = (s == 0) ? 0 : s + 1;
            apb(1'b1, CTL, POL | k);
            level <= 3'h7 ^ (3'h1 << s);
            idle(8);
            rd(CTL, POL | k, 32'hFF, 1'b0);
            level <= 3'h1 << s;
            idle(8);
            rd(CTL, POL | VAL | k, 32'hFF, 1'b0);
            level <= 3'h0;
            idle(8);
        end
        rd(FLG, 32'h1, 32'h1, 1'b0);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, tgc_pkg::ADDR_INT_MASK, 32'h1);
        idle(2);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, FLG, 32'h1);
        idle(2);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, CTL, POL | tgc_pkg::SRC_OVF);
        idle(300);
        rd(FLG, 32'h1, 32'h1, 1'b0);
        apb(1'b1, FLG, 32'h1);
        apb(1'b1, CTL, GE | POL);
        apb(1'b1, tgc_pkg::ADDR_RUN_CTRL, 32'h1);
        idle(20);
        counts();
        k = $urandom_range(400, 200);
        pulse(k, 10);
        cnt = k[15:0];
        counts();
        apb(1'b1, CTL, GE | POL | SPM);
        apb(1'b1, CTL, GE | POL | SPM | ARM);
        pulse(20, 10);
        pulse(30, 10);
        cnt = cnt + 16'h0014;
        counts();
        rd(CTL, 32'h0, ARM, 1'b0);
        // Polarity untouched while toggle is turned on
        apb(1'b1, CTL, GE | POL | TM | SPM);
        apb(1'b1, CTL, GE | POL | TM | SPM | ARM);
        pulse(10, 15);
        pulse(10, 15);
        pulse(10, 15);
        cnt = cnt + 16'h0019;
        counts();
        rd(CTL, 32'h0, ARM, 1'b0);
        apb(1'b1, CTL, POL);
        idle(8);
        rd(CTL, 32'h0, VAL, 1'b0);
        conclude();
    end
endmodule
